// ### src/serial_adapter_pkg.sv
// Shared constants, types and decoders of the serial adapter.
// Assumes a single 40 MHz core clock for every module that imports it.
package serial_adapter_pkg;
  localparam int CLK_KHZ = 40000;
  localparam int EXT_RATE_KBPS = 500;
  localparam int CYC_PER_EXT_BIT = CLK_KHZ / EXT_RATE_KBPS;

  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_16 = 2'h1;
  localparam logic [1:0] DIV_64 = 2'h2;
  localparam logic [1:0] DIV_RESET = 2'h3;
  localparam logic [6:0] RATIO_1 = 7'h01;
  localparam logic [6:0] RATIO_16 = 7'h10;
  localparam logic [6:0] RATIO_64 = 7'h40;

  localparam int CR_WORD_LO = 2;
  localparam int CR_TX_LO = 5;
  localparam int CR_RXIE = 7;
  localparam logic [1:0] TXC_TXIE = 2'h1;
  localparam logic [1:0] TXC_RTS_OFF = 2'h2;
  localparam logic [1:0] TXC_BREAK = 2'h3;
  localparam logic [7:0] CTRL_RESET = 8'h03;

  localparam int SR_RXFULL = 0;
  localparam int SR_TXEMPTY = 1;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_BITS = 4'h4,
    RX_STOP = 4'h8
  } rx_state_t;

  typedef struct packed {
    logic eight;
    logic par_en;
    logic odd;
    logic two_stop;
  } word_fmt_t;

  function automatic word_fmt_t decode_word(input logic [2:0] w);
    word_fmt_t f;
    f.eight = w[2];
    f.par_en = !w[2] || w[1];
    f.odd = w[0] && f.par_en;
    f.two_stop = (w[2:1] == 2'h0) || (w == 3'h4);
    return f;
  endfunction

  function automatic logic [6:0] div_ratio(input logic [1:0] d);
    case (d)
      DIV_16: return RATIO_16;
      DIV_64: return RATIO_64;
      default: return RATIO_1;
    endcase
  endfunction
endpackage

// ### src/tx_link_if.sv
// Link between the register side and the transmit serializer.
// Both ends run on the core clock.
`timescale 1ns/1ps
interface tx_link_if;
  logic [1:0] divide;
  logic [2:0] word;
  logic [7:0] hold_data;
  logic hold_full;
  logic brk;
  logic init;
  logic take;
  modport ctl(output divide, word, hold_data, hold_full, brk, init,
              input take);
  modport ser(input divide, word, hold_data, hold_full, brk, init,
              output take);
endinterface

// ### src/tx_serializer.sv
// Transmit shift register fed from the holding register over tx_link_if.
// Assumes tx_clk_in is synchronous to core_clk_in.
`timescale 1ns/1ps
module tx_serializer
  import serial_adapter_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic tx_clk_in,
  tx_link_if.ser lk,
  output logic tx_data_out
);
  typedef struct packed {
    logic clk_prev;
    logic [6:0] cnt;
    logic busy;
    logic [9:0] frame;
    logic [3:0] left;
    logic take;
    logic line;
  } tx_st_t;

  tx_st_t s_q;
  tx_st_t s_d;
  word_fmt_t fmt;
  logic [6:0] ratio;
  logic tick;
  logic par;

  always_comb begin
    s_d = s_q;
    fmt = decode_word(lk.word);
    ratio = div_ratio(lk.divide);
    par = fmt.odd ^ (^lk.hold_data[6:0]) ^ (fmt.eight & lk.hold_data[7]);
    s_d.clk_prev = tx_clk_in;
    s_d.take = 1'b0;
    s_d.line = s_q.busy ? s_q.line : 1'b1;
    // RULE16 falling edge launch
    tick = s_q.clk_prev && !tx_clk_in && (s_q.cnt == ratio - 7'h01);
    if (s_q.clk_prev && !tx_clk_in) begin
      s_d.cnt = tick ? 7'h00 : s_q.cnt + 7'h01;
    end
    if (lk.init) begin
      s_d.busy = 1'b0;
      s_d.cnt = 7'h00;
      s_d.line = 1'b1;
    end else if (tick) begin
      if (s_q.busy && s_q.left != 4'h0) begin
        // RULE8 start, data, parity, stops
        s_d.line = s_q.frame[0];
        s_d.frame = {1'b1, s_q.frame[9:1]};
        s_d.left = s_q.left - 4'h1;
      end else if (lk.hold_full) begin
        // RULE9 holding to shift register
        s_d.busy = 1'b1;
        s_d.take = 1'b1;
        s_d.line = 1'b0;
        if (!fmt.eight) begin
          s_d.frame = {2'h3, par, lk.hold_data[6:0]};
        end else if (fmt.par_en) begin
          s_d.frame = {1'b1, par, lk.hold_data};
        end else begin
          s_d.frame = {2'h3, lk.hold_data};
        end
        s_d.left = 4'h8 + {3'h0, fmt.eight} + {3'h0, fmt.par_en}
                   + {3'h0, fmt.two_stop};
      end else begin
        s_d.busy = 1'b0;
        s_d.line = 1'b1;
      end
    end
    // RULE26 break overrides mark
    if (lk.brk) begin
      s_d.line = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.line <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign lk.take = s_q.take;
  assign tx_data_out = s_q.line;

  // RULE16 line moves after a fall
  a_launch_on_fall: assert property (@(posedge core_clk_in) // RULE16
    disable iff (rst_in)
    ($changed(tx_data_out) && !lk.brk && !$past(lk.brk)
     && !$past(lk.init) && $past(s_q.busy))
    |-> $past(s_q.clk_prev && !tx_clk_in))
    else $error("tx bit launched without falling tx clock");
  // RULE26 idle line at mark
  a_idle_mark: assert property (@(posedge core_clk_in) // RULE26
    disable iff (rst_in)
    (!s_q.busy && !$past(lk.brk)) |-> tx_data_out)
    else $error("idle transmit line not at mark");
endmodule

// ### src/serial_adapter.sv
// Asynchronous serial adapter: register side, receiver and modem lines.
// Assumes all pins synchronous to core_clk_in; bus pins tri-stated outside.
// What this block does
// RULE1: Two addresses reach four one-way registers
// RULE2: Pick high selects data, low selects control
// RULE3: Selected only with both highs, low low
// RULE4: Drive bus on read, release otherwise
// RULE5: Enable strobe times every bus transfer
// RULE6: Held in reset until master reset write
// RULE7: Software sets transmit control with reset
// RULE8: Start, data, parity, one or two stops
// RULE9: Holding register feeds shifter when done
// RULE10: Divide one external, else internal sync
// RULE11: Half bit of space before locking
// RULE12: Report parity, framing, overrun, full
// RULE13: Seven-bit formats read bit seven zero
// RULE14: Receive holding separate from shift register
// RULE15: Open-drain interrupt low while cause enabled
// RULE16: New transmit bit on falling clock
// RULE17: Receive samples on rising clock
// RULE18: External rate up to 500 kbps
// RULE19: Clear-to-send high hides transmit empty
// RULE20: Request-to-send high for code 10 and until master reset
// RULE21: Carrier high holds receiver initialised
// RULE22: Carrier rising edge interrupts when enabled
// RULE23: Divide code 11 clears status, inits
// RULE24: Divide codes 1, 16, 64, reset
// RULE25: Control bit 7 enables receive interrupts
// RULE26: Idle transmit line rests at mark
`timescale 1ns/1ps
module serial_adapter
  import serial_adapter_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic rw_in,
  input wire logic register_pick_in,
  input wire logic select_high_a_in,
  input wire logic select_high_b_in,
  input wire logic select_low_n_in,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe_out,
  output logic irq_n_out,
  output logic irq_n_oe_out,
  input wire logic tx_clk_in,
  input wire logic rx_clk_in,
  input wire logic rx_data_in,
  output logic tx_data_out,
  input wire logic clear_to_send_n_in,
  input wire logic carrier_detect_n_in,
  output logic request_to_send_n_out
);
  // RULE18 sampling must resolve the fastest external rate
  if (CYC_PER_EXT_BIT < 4) begin : g_rate_chk
    $error("core clock too slow for external serial rate");
  end

  typedef struct packed {
    logic en_prev;
    logic por;
    logic [7:0] ctrl;
    logic [7:0] tdr;
    logic tdr_full;
    logic [7:0] rdr;
    logic rdr_full;
    logic fe;
    logic pe;
    logic ovr;
    logic dcd_prev;
    logic dcd_flag;
    logic rx_clk_prev;
    rx_state_t rx_st;
    logic [6:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [8:0] rx_sh;
    logic [7:0] dout;
    logic doe;
    logic irq;
    logic irq_lvl;
    logic rts_n;
  } adapter_st_t;

  adapter_st_t s_q;
  adapter_st_t s_d;
  tx_link_if lk();

  logic sel;
  logic strobe_end;
  logic wr;
  logic rd;
  logic hold;
  logic rx_rise;
  logic rx_tick;
  logic tx_holding_empty;
  logic [7:0] status_byte;
  logic [7:0] rx_byte;
  logic rx_par;
  logic [6:0] ratio;
  logic [3:0] nbits;
  word_fmt_t fmt;

  always_comb begin
    s_d = s_q;
    fmt = decode_word(s_q.ctrl[CR_TX_LO-1:CR_WORD_LO]);
    // RULE24 divide select
    ratio = div_ratio(s_q.ctrl[1:0]);
    nbits = 4'h7 + {3'h0, fmt.eight} + {3'h0, fmt.par_en};
    // RULE23 master reset code held
    hold = s_q.por || (s_q.ctrl[1:0] == DIV_RESET);

    // RULE3 chip select decode
    sel = select_high_a_in && select_high_b_in && !select_low_n_in;
    // RULE5 transfers on enable fall
    strobe_end = s_q.en_prev && !enable_in;
    // RULE1 direction picks register
    wr = strobe_end && sel && !rw_in;
    rd = strobe_end && sel && rw_in;
    s_d.en_prev = enable_in;

    // RULE19 clear-to-send gates empty
    tx_holding_empty = !s_q.tdr_full && !clear_to_send_n_in;
    status_byte = {s_q.irq, s_q.pe, s_q.ovr, s_q.fe, clear_to_send_n_in,
                   carrier_detect_n_in || s_q.dcd_flag, tx_holding_empty, s_q.rdr_full};

    // RULE2 register pair select
    if (wr && !register_pick_in) begin
      s_d.ctrl = host_data_bus_in;
      // RULE6 power-on hold released
      if (host_data_bus_in[1:0] == DIV_RESET) begin
        s_d.por = 1'b0;
      end
    end
    if (lk.take) begin
      s_d.tdr_full = 1'b0;
    end
    if (wr && register_pick_in) begin
      s_d.tdr = host_data_bus_in;
      s_d.tdr_full = 1'b1;
    end
    // Read clears first so a new arrival wins
    if (rd && register_pick_in) begin
      s_d.rdr_full = 1'b0;
      s_d.ovr = 1'b0;
      s_d.dcd_flag = 1'b0;
    end
    // RULE22 carrier loss edge
    s_d.dcd_prev = carrier_detect_n_in;
    if (carrier_detect_n_in && !s_q.dcd_prev) begin
      s_d.dcd_flag = 1'b1;
    end

    // RULE17 rising receive clock
    s_d.rx_clk_prev = rx_clk_in;
    rx_rise = rx_clk_in && !s_q.rx_clk_prev;
    rx_tick = rx_rise && (s_q.rx_cnt == ratio - 7'h01);
    rx_byte = fmt.eight ? s_q.rx_sh[7:0] : {1'b0, s_q.rx_sh[6:0]};
    rx_par = fmt.eight ? s_q.rx_sh[8] : s_q.rx_sh[7];

    // RULE21 carrier high inits receiver
    if (hold || carrier_detect_n_in) begin
      s_d.rx_st = RX_IDLE;
      s_d.rx_cnt = 7'h00;
      s_d.rx_idx = 4'h0;
    end else if (rx_rise) begin
      case (s_q.rx_st)
        RX_IDLE: begin
          s_d.rx_cnt = 7'h00;
          s_d.rx_idx = 4'h0;
          if (!rx_data_in) begin
            // RULE10 divide one trusts clock
            s_d.rx_st = (ratio == RATIO_1) ? RX_BITS : RX_START;
          end
        end
        RX_START: begin
          // RULE11 false start rejection
          if (rx_data_in) begin
            s_d.rx_st = RX_IDLE;
          end else if (s_q.rx_cnt == (ratio >> 1) - 7'h01) begin
            s_d.rx_st = RX_BITS;
            s_d.rx_cnt = 7'h00;
          end else begin
            s_d.rx_cnt = s_q.rx_cnt + 7'h01;
          end
        end
        RX_BITS: begin
          s_d.rx_cnt = rx_tick ? 7'h00 : s_q.rx_cnt + 7'h01;
          if (rx_tick) begin
            // RULE14 assembled apart from holding
            s_d.rx_sh[s_q.rx_idx] = rx_data_in;
            s_d.rx_idx = s_q.rx_idx + 4'h1;
            if (s_q.rx_idx == nbits - 4'h1) begin
              s_d.rx_st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          s_d.rx_cnt = rx_tick ? 7'h00 : s_q.rx_cnt + 7'h01;
          if (rx_tick) begin
            s_d.rx_st = RX_IDLE;
            // RULE12 errors and full flag
            if (s_d.rdr_full) begin
              s_d.ovr = 1'b1;
            end else begin
              // RULE13 parity stripped, bit 7 zero
              s_d.rdr = rx_byte;
              s_d.rdr_full = 1'b1;
              s_d.fe = !rx_data_in;
              s_d.pe = fmt.par_en && ((^rx_byte) ^ rx_par ^ fmt.odd);
            end
          end
        end
        default: s_d.rx_st = RX_IDLE;
      endcase
    end

    if (hold) begin
      s_d.tdr_full = 1'b0;
      s_d.rdr_full = 1'b0;
      s_d.fe = 1'b0;
      s_d.pe = 1'b0;
      s_d.ovr = 1'b0;
      s_d.dcd_flag = 1'b0;
    end

    // RULE15 level interrupt while cause enabled
    // RULE25 receive interrupt enable
    s_d.irq = !hold && ((s_q.ctrl[CR_RXIE] && (s_q.rdr_full
              || s_q.dcd_flag || s_q.ovr)) || (tx_holding_empty
              && s_q.ctrl[CR_RXIE-1:CR_TX_LO] == TXC_TXIE));
    s_d.irq_lvl = 1'b0;
    // RULE20 request-to-send decode
    s_d.rts_n = s_q.por
                || (s_q.ctrl[CR_RXIE-1:CR_TX_LO] == TXC_RTS_OFF);
    // RULE4 drive only on selected read
    s_d.doe = enable_in && sel && rw_in;
    s_d.dout = 8'h00;
    if (enable_in && sel && rw_in) begin
      s_d.dout = register_pick_in ? s_q.rdr : status_byte;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.por <= 1'b1;
      s_q.ctrl <= CTRL_RESET;
      s_q.dcd_prev <= 1'b1;
      s_q.rx_st <= RX_IDLE;
      s_q.rts_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign lk.divide = s_q.ctrl[1:0];
  assign lk.word = s_q.ctrl[CR_TX_LO-1:CR_WORD_LO];
  assign lk.hold_data = s_q.tdr;
  assign lk.hold_full = s_q.tdr_full;
  assign lk.init = hold;
  assign lk.brk = !s_q.por
                  && (s_q.ctrl[CR_RXIE-1:CR_TX_LO] == TXC_BREAK);

  tx_serializer u_tx (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .tx_clk_in(tx_clk_in),
    .lk(lk.ser),
    .tx_data_out(tx_data_out)
  );

  assign host_data_bus_out = s_q.dout;
  assign host_data_bus_oe_out = s_q.doe;
  assign irq_n_out = s_q.irq_lvl;
  assign irq_n_oe_out = s_q.irq;
  assign request_to_send_n_out = s_q.rts_n;

  a_bus_release: assert property (@(posedge core_clk_in) // RULE4
    disable iff (rst_in) !rw_in |=> !host_data_bus_oe_out)
    else $error("data bus driven during write");
  a_rts_code: assert property (@(posedge core_clk_in) // RULE20
    disable iff (rst_in) !$past(s_q.por) |-> request_to_send_n_out
    == ($past(s_q.ctrl[6:5]) == TXC_RTS_OFF))
    else $error("request-to-send does not follow control");
  a_cts_gate: assert property (@(posedge core_clk_in) // RULE19
    disable iff (rst_in)
    clear_to_send_n_in |-> !status_byte[SR_TXEMPTY])
    else $error("transmit empty shown while clear-to-send high");
  a_rx_irq: assert property (@(posedge core_clk_in) // RULE15
    disable iff (rst_in) (s_q.ctrl[CR_RXIE] && s_q.rdr_full && !hold)
    |=> irq_n_oe_out)
    else $error("receive full did not pull interrupt");
  a_dcd_edge: assert property (@(posedge core_clk_in) // RULE22
    disable iff (rst_in)
    ($rose(carrier_detect_n_in) && !hold) |=> s_q.dcd_flag)
    else $error("carrier loss edge not latched");
  a_rx_inhibit: assert property (@(posedge core_clk_in) // RULE21
    disable iff (rst_in) carrier_detect_n_in |=> s_q.rx_st == RX_IDLE)
    else $error("receiver active while carrier lost");
  a_seven_zero: assert property (@(posedge core_clk_in) // RULE13
    disable iff (rst_in)
    ($rose(s_q.rdr_full) && !$past(s_q.ctrl[4])) |-> !s_q.rdr[7])
    else $error("bit 7 set in seven-bit format");
  a_false_start: assert property (@(posedge core_clk_in) // RULE11
    disable iff (rst_in) (s_q.rx_st == RX_START && rx_rise && rx_data_in
    && !hold && !carrier_detect_n_in) |=> s_q.rx_st == RX_IDLE)
    else $error("false start bit accepted");
  a_por_quiet: assert property (@(posedge core_clk_in) // RULE6
    disable iff (rst_in) s_q.por |-> (request_to_send_n_out
    && !irq_n_oe_out && tx_data_out))
    else $error("output moved before master reset");
endmodule

// ### verification/serial_peer.sv
// Far-end serial peer: bit clock source, frame sender and frame catcher.
// Assumes the adapter samples the bit clock and data on its core clock.
`timescale 1ns/1ps
module serial_peer
  import serial_adapter_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic tx_data_in,
  output logic bit_clk_out,
  output logic rx_data_out
);
  initial begin
    bit_clk_out = 1'b0;
    rx_data_out = 1'b1;
    forever begin
      repeat (CYC_PER_EXT_BIT / 2) @(negedge core_clk_in);
      bit_clk_out = ~bit_clk_out;
    end
  end

  task automatic send(input int ratio, input int n, input logic [11:0] f);
    for (int i = 0; i < n; i++) begin
      @(negedge bit_clk_out);
      rx_data_out = f[i];
      repeat (ratio - 1) @(negedge bit_clk_out);
    end
    @(negedge bit_clk_out);
    rx_data_out = 1'b1;
  endtask

  task automatic false_start(input int k);
    @(negedge bit_clk_out);
    rx_data_out = 1'b0;
    repeat (k) @(negedge bit_clk_out);
    rx_data_out = 1'b1;
  endtask

  // Sampling on rises keeps clear of the launch delay
  task automatic catch_frame(input int n, output logic [11:0] f);
    f = 12'h000;
    f[0] = 1'b1;
    for (int t = 0; t < 200 && f[0]; t++) begin
      @(posedge bit_clk_out);
      f[0] = tx_data_in;
    end
    for (int i = 1; i < n; i++) begin
      @(posedge bit_clk_out);
      f[i] = tx_data_in;
    end
  endtask
endmodule

// ### verification/tb.sv
// Self-checking bench for the serial adapter with a serial peer model.
// Assumes bus inputs change on falling core clock edges only.
`timescale 1ns/1ps
module tb;
  import serial_adapter_pkg::*;
  logic core_clk_in, rst_in, enable, rw, pick, sel_a, sel_b, sel_low_n;
  logic cts_n, dcd_n;
  logic [7:0] wdata, rdata;
  logic oe, irq_n, irq_oe, txd, rts_n, bclk, rxd;
  int bad_count = 0;
  int checked = 0;

  serial_adapter dut_u (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .enable_in(enable),
    .rw_in(rw), .register_pick_in(pick), .select_high_a_in(sel_a),
    .select_high_b_in(sel_b), .select_low_n_in(sel_low_n),
    .host_data_bus_in(wdata), .host_data_bus_out(rdata),
    .host_data_bus_oe_out(oe), .irq_n_out(irq_n), .irq_n_oe_out(irq_oe),
    .tx_clk_in(bclk), .rx_clk_in(bclk), .rx_data_in(rxd),
    .tx_data_out(txd), .clear_to_send_n_in(cts_n),
    .carrier_detect_n_in(dcd_n), .request_to_send_n_out(rts_n));

  serial_peer peer_u (.core_clk_in(core_clk_in), .tx_data_in(txd),
    .bit_clk_out(bclk), .rx_data_out(rxd));

  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  task automatic end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic p, input logic [7:0] d);
    @(negedge core_clk_in);
    pick = p;
    rw = 1'b0;
    wdata = d;
    enable = 1'b1;
    @(negedge core_clk_in);
    enable = 1'b0;
    @(negedge core_clk_in);
  endtask

  task automatic rd(input logic p, output logic [7:0] d);
    @(negedge core_clk_in);
    pick = p;
    rw = 1'b1;
    enable = 1'b1;
    @(negedge core_clk_in);
    d = rdata;
    chk({11'h0, oe}, 12'h001);
    enable = 1'b0;
    repeat (2) @(negedge core_clk_in);
    chk({11'h0, oe}, 12'h000);
  endtask

  task automatic st(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] s;
    rd(1'b0, s);
    chk({4'h0, s & m}, {4'h0, e});
  endtask

  task automatic t_hold;
    logic low;
    low = 1'b0;
    chk({8'h0, txd, rts_n, oe, irq_oe}, 12'h00C);
    sel_b = 1'b0;
    rw = 1'b1;
    enable = 1'b1;
    repeat (2) @(negedge core_clk_in);
    chk({11'h0, oe}, 12'h000);
    enable = 1'b0;
    @(negedge core_clk_in);
    sel_b = 1'b1;
    wr(1'b1, 8'h00);
    for (int i = 0; i < 400; i++) begin
      @(negedge core_clk_in);
      low = low | !txd;
    end
    chk({11'h0, low}, 12'h000);
  endtask

  task automatic t_setup;
    logic [1:0] c;
    wr(1'b0, 8'h03);
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      wr(1'b0, {1'b0, c, 5'h1C});
      repeat (4) @(negedge core_clk_in);
      chk({9'h0, rts_n, txd, irq_oe}, {9'h0, c == 2'h2, c != 2'h3,
        c == 2'h1});
    end
    wr(1'b0, 8'h1C);
  endtask

  task automatic t_tx;
    logic [11:0] fa, fb;
    fork
      begin
        peer_u.catch_frame(11, fa);
        peer_u.catch_frame(11, fb);
      end
      begin
        // Align to a bit clock fall so the load cannot race the status read
        @(negedge bclk);
        wr(1'b1, 8'hA5);
        repeat (4) @(negedge core_clk_in);
        st(8'h02, 8'h00);
        wait_empty();
        wr(1'b1, 8'h3C);
      end
    join
    chk(fa, {2'b01, ~^8'hA5, 8'hA5, 1'b0});
    chk(fb, {2'b01, ~^8'h3C, 8'h3C, 1'b0});
  endtask

  task automatic wait_empty;
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 100 && s[SR_TXEMPTY] !== 1'b1; i++) begin
      rd(1'b0, s);
    end
    chk({11'h0, s[SR_TXEMPTY]}, 12'h001);
  endtask

  task automatic t_rx;
    logic [7:0] x;
    logic [6:0] d;
    wr(1'b0, 8'h08);
    for (int k = 0; k < 3; k++) begin
      d = 7'h35 + 7'(k);
      peer_u.send(1, 10, {2'b11, k != 2, (^d) ^ (k == 1), d, 1'b0});
      repeat (20) @(negedge core_clk_in);
      st(8'h51, {1'b0, k == 1, 1'b0, k == 2, 4'h1});
      rd(1'b1, x);
      chk({4'h0, x}, {5'h00, d});
    end
    peer_u.send(1, 10, {3'b111, 1'b0, 7'h11, 1'b0});
    peer_u.send(1, 10, {3'b111, 1'b0, 7'h22, 1'b0});
    repeat (20) @(negedge core_clk_in);
    st(8'h21, 8'h21);
    rd(1'b1, x);
    chk({4'h0, x}, 12'h011);
    st(8'h21, 8'h00);
  endtask

  task automatic t_carrier;
    logic [7:0] x;
    for (int ie = 0; ie < 2; ie++) begin
      wr(1'b0, {ie[0], 7'h08});
      dcd_n = 1'b1;
      if (ie == 0) begin
        peer_u.send(1, 10, {3'b111, 1'b0, 7'h11, 1'b0});
      end
      repeat (20) @(negedge core_clk_in);
      st(8'h85, {ie[0], 7'h04});
      chk({11'h0, irq_oe}, {11'h0, ie[0]});
      chk({11'h0, irq_n}, 12'h000);
      rd(1'b1, x);
      dcd_n = 1'b0;
      st(8'h84, 8'h00);
    end
  endtask

  task automatic t_cts;
    cts_n = 1'b1;
    repeat (4) @(negedge core_clk_in);
    st(8'h0A, 8'h08);
    cts_n = 1'b0;
    repeat (4) @(negedge core_clk_in);
    st(8'h0A, 8'h02);
  endtask

  task automatic t_div16;
    logic [7:0] x;
    wr(1'b0, 8'h09);
    peer_u.false_start(4);
    repeat (320) @(negedge core_clk_in);
    st(8'h01, 8'h00);
    peer_u.send(16, 10, {3'b111, 1'b1, 7'h2A, 1'b0});
    repeat (20) @(negedge core_clk_in);
    rd(1'b1, x);
    chk({4'h0, x}, 12'h02A);
  endtask

  task automatic t_mreset;
    wr(1'b0, 8'h48);
    peer_u.send(1, 10, {3'b111, 1'b0, 7'h11, 1'b0});
    repeat (20) @(negedge core_clk_in);
    st(8'h01, 8'h01);
    wr(1'b0, 8'h4B);
    st(8'h01, 8'h00);
    chk({11'h0, rts_n}, 12'h001);
  endtask

  // Watchdog well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge core_clk_in);
    bad_count++;
    end_of_test();
  end

  initial begin
    rst_in = 1'b1;
    enable = 1'b0;
    rw = 1'b1;
    pick = 1'b0;
    sel_a = 1'b1;
    sel_b = 1'b1;
    sel_low_n = 1'b0;
    wdata = 8'h00;
    cts_n = 1'b0;
    dcd_n = 1'b0;
    repeat (8) @(negedge core_clk_in);
    rst_in = 1'b0;
    t_hold();
    t_setup();
    t_tx();
    t_rx();
    t_carrier();
    t_cts();
    t_div16();
    t_mreset();
    end_of_test();
  end
endmodule
